/* File: rtl/pbs_pkg.sv */
// shared constants and carrier types for the pipelined burst sram port
package pbs_pkg;

    // widest data word: four lanes of eight data bits plus one parity bit
    localparam int LANE_W     = 9;
    localparam int DATA_W     = 36;
    localparam int LANES      = DATA_W / LANE_W;
    localparam int ADDR_W     = 19;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 32;

    // strap level that picks the linear order; high or floating is interleaved
    localparam logic MODE_LINEAR = 1'b0;

    // values after reset, plus the burst counter increment
    localparam logic [BURST_W-1:0] BURST_RST   = 2'h0;
    localparam logic [BURST_W-1:0] BURST_INC   = 2'h1;
    localparam logic               OE_N_RST    = 1'b1;
    localparam logic               TDO_RST     = 1'b0;

    // synchronous control pins, all sampled on the rising clock
    typedef struct packed {
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_step_n;
        logic chip_select_lo_a;
        logic chip_select_hi;
        logic chip_select_lo_b;
        logic global_write_n;
        logic byte_write_gate_n;
    } pbs_ctrl_t;

    // one posted write on its way to the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  lane_en;
    } pbs_wr_req_t;

    // what the current bus cycle is doing
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_READ,
        CYC_WRITE
    } pbs_cycle_t;

endpackage

/* File: rtl/pbs_sram_port.sv */
// pipelined burst sram port with posted write buffer and boundary-scan bypass
// What this block does
// - capture input data on rising clock
// - read data from previous edge's address
// - output enable low drives, high floats pins
// - strap low linear, high interleaved burst
// - scan output changes on falling test clock
// - scan inputs sampled on rising test clock
// - inputs and data outputs pass registers
// - two-bit wrap counter makes burst addresses
// - byte write needs lane and gate
// - global write writes every lane
// - read start conditions; processor strobe gated
// - start loads address register and counter
// - read data driven after next edge
// - first cycle from deselect stays floating
// - back-to-back reads without idle cycles
// - deselect floats outputs at once
// - both strobes low: processor strobe wins
// - burst step low advances counter
// - write cycle forces outputs floating
`timescale 1ns/1ns
`default_nettype none

module pbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = pbs_pkg::FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] store_r [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic             push;
    logic             pop;

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_valid = (count_r != '0);
    assign out_data  = store_r[rd_ptr_r];

    // occupancy; ready is kept registered so the source sees a clean flag
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + CNT_W'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_r  <= '0;
            in_ready <= 1'b1;
        end else begin
            count_r  <= count_nxt;
            in_ready <= (count_nxt != CNT_FULL);
        end
    end

    // pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PTR_W'(1);
            end
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            store_r[wr_ptr_r] <= in_data;
        end
    end
endmodule

module pbs_sram_port #(
    parameter int DATA_W = pbs_pkg::DATA_W,
    parameter int LANES  = DATA_W / pbs_pkg::LANE_W
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [pbs_pkg::ADDR_W-1:0] addr,
    input  wire pbs_pkg::pbs_ctrl_t        ctrl,
    input  wire logic [LANES-1:0]          byte_lane_select_n,
    input  wire logic                      output_enable_n,
    input  wire logic                      burst_mode,
    input  wire logic [DATA_W-1:0]         dq_in,
    output logic [DATA_W-1:0]              dq_out,
    output logic                           dq_oe_n,
    output logic                           wr_ready,
    input  wire logic                      tck,
    input  wire logic                      tdi,
    input  wire logic                      tms,
    output logic                           tdo
);
    localparam int AW = pbs_pkg::ADDR_W;
    localparam int BW = pbs_pkg::BURST_W;
    localparam int LW = pbs_pkg::LANE_W;
    localparam int RW = $bits(pbs_pkg::pbs_wr_req_t);

    logic [DATA_W-1:0]  mem_r [0:(2**AW)-1];
    pbs_pkg::pbs_cycle_t cycle_r;
    logic               mode_r;
    logic [AW-BW-1:0]   base_r;
    logic [BW-1:0]      first_r;
    logic [BW-1:0]      step_r;
    logic [BW-1:0]      step_nxt;
    logic [BW-1:0]      low_nxt;
    logic [AW-1:0]      cur_addr;
    logic [AW-1:0]      rd_addr_r;
    logic               rd_pend_r;
    logic               tck_q_r;
    logic               bypass_r;
    logic               sel_ok;
    logic               proc_go;
    logic               ctrl_go;
    logic               wr_any;
    logic [LANES-1:0]   lane_en;
    logic               start_rd;
    logic               start_wr;
    logic               deselect;
    logic               cont;
    logic               cont_rd;
    logic               cont_wr;
    logic               wr_now;
    logic               rd_now;
    pbs_pkg::pbs_wr_req_t wr_req;
    pbs_pkg::pbs_wr_req_t drain_req;
    logic [RW-1:0]      drain_bits;
    logic               drain_valid;
    logic               drain_ready;

    // strobe qualification; processor strobe is dead while the first select is high
    assign sel_ok  = ~ctrl.chip_select_lo_a & ctrl.chip_select_hi & ~ctrl.chip_select_lo_b;
    assign proc_go = ~ctrl.proc_addr_strobe_n & ~ctrl.chip_select_lo_a;
    assign ctrl_go = ~ctrl.ctrl_addr_strobe_n & ~proc_go;

    // write qualifiers: global write beats every lane select
    assign lane_en = ~ctrl.global_write_n ? {LANES{1'b1}} :
                     (~ctrl.byte_write_gate_n ? ~byte_lane_select_n : '0);
    assign wr_any  = |lane_en;

    // cycle decode; a processor-strobed start is always a read
    assign start_rd = sel_ok & (proc_go | (ctrl_go & ctrl.global_write_n
                      & ctrl.byte_write_gate_n));
    assign start_wr = sel_ok & ctrl_go & ~start_rd & wr_any;
    assign deselect = (proc_go | ctrl_go) & ~sel_ok;
    assign cont     = ~proc_go & ~ctrl_go & (cycle_r != pbs_pkg::CYC_IDLE);
    assign cont_wr  = cont & wr_any;
    assign cont_rd  = cont & ~wr_any;
    assign wr_now   = start_wr | cont_wr;
    assign rd_now   = start_rd | cont_rd;

    // burst order: offset added for linear, xor-ed for interleaved
    assign step_nxt = (cont && !ctrl.burst_step_n) ? step_r + pbs_pkg::BURST_INC : step_r;
    assign low_nxt  = (mode_r == pbs_pkg::MODE_LINEAR) ? first_r + step_nxt
                                                       : first_r ^ step_nxt;
    assign cur_addr = cont ? {base_r, low_nxt} : addr;

    // the strap is taken while reset is held; it must not move afterwards
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_r <= burst_mode;
        end
    end

    // cycle tracking; a bare strobe with a bad select deselects
    always_ff @(posedge clock) begin
        if (rst) begin
            cycle_r <= pbs_pkg::CYC_IDLE;
        end else if (start_rd || cont_rd) begin
            cycle_r <= pbs_pkg::CYC_READ;
        end else if (wr_now) begin
            cycle_r <= pbs_pkg::CYC_WRITE;
        end else if (deselect) begin
            cycle_r <= pbs_pkg::CYC_IDLE;
        end
    end

    // address register and two-bit wraparound counter
    always_ff @(posedge clock) begin
        if (rst) begin
            base_r  <= '0;
            first_r <= pbs_pkg::BURST_RST;
            step_r  <= pbs_pkg::BURST_RST;
        end else if (start_rd || start_wr) begin
            base_r  <= addr[AW-1:BW];
            first_r <= addr[BW-1:0];
            step_r  <= pbs_pkg::BURST_RST;
        end else if (cont) begin
            step_r  <= step_nxt;
        end
    end

    // read pipeline: address taken at this edge, word leaves at the next
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= '0;
        end else begin
            rd_pend_r <= rd_now;
            rd_addr_r <= cur_addr;
        end
    end

    // output register doubles as the array read port
    always_ff @(posedge clock) begin
        if (rst) begin
            dq_out <= '0;
        end else if (rd_pend_r) begin
            dq_out <= mem_r[rd_addr_r];
        end
    end

    // pin direction; enable is sampled, so it acts one edge late
    always_ff @(posedge clock) begin
        if (rst) begin
            dq_oe_n <= pbs_pkg::OE_N_RST;
        end else if (wr_now) begin
            dq_oe_n <= 1'b1;
        end else if (deselect) begin
            dq_oe_n <= 1'b1;
        end else if (start_rd && cycle_r == pbs_pkg::CYC_IDLE) begin
            dq_oe_n <= 1'b1;
        end else begin
            dq_oe_n <= ~(rd_pend_r & ~output_enable_n);
        end
    end

    // posted write: data word captured at the edge it is presented
    always_comb begin
        wr_req = '0;
        wr_req.addr = cur_addr;
        wr_req.data[DATA_W-1:0] = dq_in;
        wr_req.lane_en[LANES-1:0] = lane_en;
    end

    // writes drain only in cycles the read port leaves free
    assign drain_ready = ~rd_pend_r;
    assign drain_req   = pbs_pkg::pbs_wr_req_t'(drain_bits);

    pbs_fifo #(
        .WIDTH (RW),
        .DEPTH (pbs_pkg::FIFO_DEPTH)
    ) u_wr_buf (
        .clock     (clock),
        .rst       (rst),
        .in_data   (wr_req),
        .in_valid  (wr_now),
        .in_ready  (wr_ready),
        .out_data  (drain_bits),
        .out_valid (drain_valid),
        .out_ready (drain_ready)
    );

    // array write, one nine-bit lane per select
    always_ff @(posedge clock) begin
        if (drain_valid && drain_ready) begin
            for (int i = 0; i < LANES; i++) begin
                if (drain_req.lane_en[i]) begin
                    mem_r[drain_req.addr][i*LW +: LW] <= drain_req.data[i*LW +: LW];
                end
            end
        end
    end

    // test clock treated as a sampled level; only the bypass path is kept
    always_ff @(posedge clock) begin
        if (rst) begin
            tck_q_r  <= 1'b0;
            bypass_r <= 1'b0;
            tdo      <= pbs_pkg::TDO_RST;
        end else begin
            tck_q_r <= tck;
            if (tck && !tck_q_r) begin
                bypass_r <= tdi ^ (tms & 1'b0);
            end
            if (!tck && tck_q_r) begin
                tdo <= bypass_r;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verification/pbs_bus_model.sv */
// far-side master model: strap holder and data bus resolution
`timescale 1ns/1ns
`default_nettype none
module pbs_bus_model #(
    parameter int W = 36
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         mode_req,
    output logic              burst_mode,
    input  wire logic [W-1:0] dq_out,
    input  wire logic         dq_oe_n,
    input  wire logic [W-1:0] drv_data,
    input  wire logic         drv_en,
    output logic [W-1:0]      bus
);
    logic [W-1:0] last_r;

    // strap only follows the request while the device is in reset
    always_latch begin
        if (rst) begin
            burst_mode <= mode_req;
        end
    end

    // wire level; an undriven bus shows the inverse of its last value
    always_comb begin
        if (!dq_oe_n) begin
            bus = dq_out;
        end else if (drv_en) begin
            bus = drv_data;
        end else begin
            bus = ~last_r;
        end
    end

    // history for the floating pattern
    always_ff @(posedge clock) begin
        last_r <= bus;
    end
endmodule
`default_nettype wire

/* File: verification/pbs_sram_port_asserts.sv */
// pin-level assertions for the pipelined burst sram port
`timescale 1ns/1ns
`default_nettype none
module pbs_sram_port_asserts (
    input wire logic               clock,
    input wire logic               rst,
    input wire pbs_pkg::pbs_ctrl_t ctrl,
    input wire logic               output_enable_n,
    input wire logic               dq_oe_n,
    input wire logic               tck,
    input wire logic               tdo
);
    logic sel_ok;
    logic p_act;
    logic c_act;
    logic rd_st;
    logic wr_st;
    logic desel;

    // decode of the control pins; byte writes left out to keep it small
    assign sel_ok = !ctrl.chip_select_lo_a && ctrl.chip_select_hi && !ctrl.chip_select_lo_b;
    assign p_act = !ctrl.proc_addr_strobe_n && !ctrl.chip_select_lo_a;
    assign c_act = !ctrl.ctrl_addr_strobe_n && !p_act;
    assign rd_st = sel_ok && (p_act || (c_act && ctrl.global_write_n && ctrl.byte_write_gate_n));
    assign wr_st = sel_ok && c_act && !ctrl.global_write_n;
    assign desel = (p_act || !ctrl.ctrl_addr_strobe_n) && !sel_ok;

    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    // two reads in a row, the second with output enable on
    sequence s_rd2;
        rd_st ##1 (rd_st && !output_enable_n);
    endsequence
    // a read straight after a deselect
    sequence s_wake;
        desel ##1 rd_st;
    endsequence

    a_reset_idle: assert property ($fell(rst) |-> dq_oe_n && !tdo)
        else $error("outputs not idle after reset");
    a_write_float: assert property (wr_st |=> dq_oe_n)
        else $error("driving after a write cycle");
    a_desel_float: assert property (desel |=> dq_oe_n)
        else $error("driving after a deselect");
    a_oe_masks: assert property (output_enable_n |=> dq_oe_n)
        else $error("driving with output enable high");
    a_read_drive: assert property (s_rd2 |=> !dq_oe_n)
        else $error("back-to-back read not driven");
    a_wake_float: assert property (s_wake |=> dq_oe_n)
        else $error("first cycle after deselect driven");
    a_tdo_hold_hi: assert property (tck [*6] |=> $stable(tdo))
        else $error("scan output moved while test clock high");
    a_tdo_hold_lo: assert property (!tck [*6] |=> $stable(tdo))
        else $error("scan output moved long after fall");
endmodule

bind pbs_sram_port pbs_sram_port_asserts u_chk (
    .clock          (clock),
    .rst            (rst),
    .ctrl           (ctrl),
    .output_enable_n(output_enable_n),
    .dq_oe_n        (dq_oe_n),
    .tck            (tck),
    .tdo            (tdo)
);
`default_nettype wire

/* File: verification/pbs_sram_port_tb.sv */
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ns
`default_nettype none
module pbs_sram_port_tb;
    logic               clock = 1'b0;
    logic               rst = 1'b1;
    logic [18:0]        addr = 19'h0;
    pbs_pkg::pbs_ctrl_t ctrl = 8'heb;
    logic [3:0]         bl_n = 4'hf;
    logic               oe_n = 1'b1;
    logic               mode_req = 1'b0;
    logic               burst_mode;
    logic [35:0]        dq_in;
    logic [35:0]        dq_out;
    logic [35:0]        wd = 36'h0;
    logic               we = 1'b0;
    logic               dq_oe_n;
    logic               wr_ready;
    logic               tck = 1'b0;
    logic               tdi = 1'b0;
    logic               tdo;
    logic [35:0]        m [0:7];
    int                 n_errors = 0;
    int                 checked = 0;
    // control patterns: idle, proc read, ctrl read, global write, byte write,
    // step, deselect, gated proc strobe, both strobes with global write,
    // unstrobed global write that continues a processor-strobed cycle
    localparam logic [7:0] KIND [0:9] = '{8'heb, 8'h6b, 8'hab, 8'ha9, 8'haa, 8'hcb,
                                          8'ha3, 8'h7b, 8'h29, 8'he9};

    always #4 clock = ~clock;

    pbs_sram_port u_pbs_sram_port (.clock(clock), .rst(rst), .addr(addr), .ctrl(ctrl),
        .byte_lane_select_n(bl_n), .output_enable_n(oe_n), .burst_mode(burst_mode),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wr_ready(wr_ready),
        .tck(tck), .tdi(tdi), .tms(1'b0), .tdo(tdo));
    pbs_bus_model u_pbs_bus_model (.clock(clock), .rst(rst), .mode_req(mode_req),
        .burst_mode(burst_mode), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .drv_data(wd),
        .drv_en(we), .bus(dq_in));

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one bus cycle, set up at the falling edge; master drives data only on writes
    task automatic op(input int k, input logic [18:0] a, input logic [35:0] d,
                      input logic [3:0] ln);
        @(negedge clock);
        ctrl = KIND[k];
        addr = a;
        wd = d;
        bl_n = ~ln;
        we = (k == 3 || k == 4 || k == 9);
    endtask

    // write cycle plus the expected merge of enabled lanes
    task automatic wr(input int k, input logic [18:0] a, input logic [35:0] d,
                      input logic [3:0] ln);
        op(k, a, d, ln);
        for (int l = 0; l < 4; l++) begin
            if (k == 3 || k == 9 || ln[l]) m[a[2:0]][9*l+:9] = d[9*l+:9];
        end
    endtask

    task automatic do_reset(input logic mode);
        @(negedge clock);
        rst = 1'b1;
        mode_req = mode;
        wt(4);
        chk(dq_oe_n, 1'b1);
        chk(dq_out, 36'h0);
        chk({wr_ready, tdo}, 2'h2);
        rst = 1'b0;
        $display("reset done");
    endtask

    // five global writes, a byte write and a gateless lane select, then drain
    task automatic t_fill;
        for (int i = 0; i < 5; i++) begin
            wr(3, 19'h100 + 19'(i), 36'h9a5c3f0e1 + 36'(i) * 36'h010203041, 4'h0);
        end
        wr(4, 19'h104, 36'h0f0f0f0f0, 4'h5);
        chk(dq_oe_n, 1'b1);
        op(2, 19'h104, 36'h0, 4'hf);
        op(6, 19'h0, 36'h0, 4'h0);
        wt(40);
        chk(wr_ready, 1'b1);
        $display("t_fill done");
    endtask

    task automatic t_reads;
        op(1, 19'h100, 36'h0, 4'h0);
        op(1, 19'h101, 36'h0, 4'h0);
        chk(dq_oe_n, 1'b1);
        op(2, 19'h104, 36'h0, 4'h0);
        chk(dq_out, m[0]);
        chk(dq_oe_n, 1'b0);
        op(0, 19'h0, 36'h0, 4'h0);
        chk(dq_out, m[1]);
        op(6, 19'h0, 36'h0, 4'h0);
        chk(dq_out, m[4]);
        op(0, 19'h0, 36'h0, 4'h0);
        chk(dq_oe_n, 1'b1);
        op(7, 19'h102, 36'h0, 4'h0);
        op(0, 19'h0, 36'h0, 4'h0);
        op(0, 19'h0, 36'h0, 4'h0);
        chk(dq_oe_n, 1'b1);
        op(8, 19'h103, 36'h0, 4'h0);
        op(0, 19'h0, 36'h0, 4'h0);
        op(0, 19'h0, 36'h0, 4'h0);
        chk(dq_out, m[3]);
        chk(dq_oe_n, 1'b0);
        oe_n = 1'b1;
        wt(2);
        chk(dq_oe_n, 1'b1);
        oe_n = 1'b0;
        op(6, 19'h0, 36'h0, 4'h0);
        op(0, 19'h0, 36'h0, 4'h0);
        $display("t_reads done");
    endtask

    // processor-strobed start, then a global write on the following edge;
    // output enable stays low, so the pins float only on the read start from idle, the write cycle, the deselect and edges with no read pending
    task automatic t_pwrite;
        op(1, 19'h105, 36'h0, 4'h0);
        wr(9, 19'h105, 36'h3c3c3c3c3, 4'h0);
        chk(dq_oe_n, 1'b1);
        op(6, 19'h0, 36'h0, 4'h0);
        chk(dq_oe_n, 1'b1);
        wt(2);
        op(2, 19'h105, 36'h0, 4'h0);
        op(0, 19'h0, 36'h0, 4'h0);
        op(6, 19'h0, 36'h0, 4'h0);
        chk(dq_out, m[5]);
        chk(dq_oe_n, 1'b0);
        $display("t_pwrite done");
    endtask

    // burst of four from low bits 01; data trails the address by two calls
    task automatic t_burst(input logic il);
        logic [1:0] e;
        for (int j = 0; j < 6; j++) begin
            op(j == 0 ? 1 : (j < 4 ? 5 : 0), 19'h101, 36'h0, 4'h0);
            if (j >= 2) begin
                e = il ? (2'h1 ^ 2'(j - 2)) : (2'h1 + 2'(j - 2));
                chk(dq_out, m[{1'b0, e}]);
            end
        end
        op(6, 19'h0, 36'h0, 4'h0);
        $display("t_burst done");
    endtask

    // slow test clock; bypass bit shows on the scan output after each fall
    task automatic t_scan;
        for (int i = 0; i < 8; i++) begin
            tdi = i[0] ^ i[1];
            tck = 1'b1;
            wt(8);
            tck = 1'b0;
            wt(8);
            chk(tdo, tdi);
        end
        $display("t_scan done");
    endtask

    initial begin
        do_reset(1'b0);
        oe_n = 1'b0;
        t_fill;
        t_reads;
        t_pwrite;
        t_burst(1'b0);
        do_reset(1'b1);
        t_fill;
        t_burst(1'b1);
        t_scan;
        end_sim;
    end

    // hang guard, well above the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clock);
        n_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
